// ==== hdl/apc_pkg.sv ====
// Package for the pulse index codec: Q14 gain constants, types.
// Assumes one core clock; all 16-bit constants Q14 unless noted.
`default_nettype none
package apc_pkg;
	localparam int Q            = 14;
	localparam int NSMP         = 64;
	localparam int NTRK         = 4;
	localparam int FR_M         = 4;
	localparam int HR_M         = 5;
	localparam int FR_BITS      = 2 * FR_M + 1;
	localparam int HR_BITS      = HR_M + 1;
	localparam int DIV_STEPS    = 14;
	localparam int FIFO_DEPTH   = 8;
	localparam logic [15:0] G_INIT   = 16'h2666; // 0.6
	localparam logic [15:0] G_HIGH   = 16'h399A; // 0.9
	localparam logic [15:0] G_ONE    = 16'h4000; // 1.0
	localparam logic [15:0] GP_CAP   = 16'h3CCD; // 0.95
	localparam logic [15:0] K_OLD_G  = 16'h399A; // 0.9
	localparam logic [15:0] K_NEW_G  = 16'h0666; // 0.1
	localparam logic [15:0] K_OLD_D  = 16'h3333; // 0.8
	localparam logic [15:0] K_NEW_D  = 16'h0CCD; // 0.2
	localparam logic [15:0] K_PER    = 16'h3666; // 0.85
	localparam logic [15:0] BETA_MAX = 16'h2000; // 0.5
	localparam logic [15:0] D_INIT   = 16'h0078; // 120 Hz
	localparam logic [15:0] D_LOW    = 16'h003C; // 60 Hz
	localparam int          DROP_SH  = 2;        // 6 dB is energy x4

	typedef enum logic [2:0] {
		APC_FULL_RATE_TYPE,
		APC_HALF_RATE_TYPE_GENERIC,
		APC_HALF_RATE_TYPE_VOICED,
		APC_HALF_RATE_TYPE_UNVOICED,
		APC_QUARTER_RATE_TYPE,
		APC_EIGHTH_RATE_TYPE
	} apc_ftype_t;

	typedef struct packed {
		logic       neg;
		logic [5:0] pos;
	} apc_pulse_t;

	typedef struct packed {
		apc_ftype_t            ftype;
		logic [15:0]           gp;
		logic [15:0]           dmin;
		logic [31:0]           tgt_energy;
		logic [7:0]            pitch_int;
		logic [31:0]           ev;
		logic [31:0]           ec;
		apc_pulse_t [7:0]      pulses;
		logic [35:0]           code_in;
	} apc_cfg_t;

	typedef struct packed {
		logic signed [15:0] h;
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic [7:0]         t;
	} apc_smp_t;

	typedef struct packed {
		logic signed [15:0] h;
		logic signed [15:0] x2;
	} apc_out_t;
endpackage : apc_pkg
`default_nettype wire

// ==== hdl/apc_codec.sv ====
// Pulse index codec: gain means and clipping, pre-filter of h(n),
// target update, pulse index packing and unpacking.
// Assumes upstream logic on core_clk; samples arrive in order 0..63.
`default_nettype none
////////////////////////////////////////////////////////////////
module apc_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] s_data,
	input  wire logic         s_valid,
	output logic              s_ready,
	output logic [W-1:0]      m_data,
	output logic              m_valid,
	input  wire logic         m_ready
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
		logic                room;
	} apc_fst_t;
	apc_fst_t st_reg, st_next;
	logic push, pop;

	// Registered room flag keeps the ready path flop-driven
	assign s_ready = st_reg.room;
	assign m_valid = st_reg.cnt != '0;
	assign m_data  = st_reg.mem[st_reg.rp];
	assign push    = s_valid && st_reg.room;
	assign pop     = m_valid && m_ready;

	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wp] = s_data;
			st_next.wp = st_reg.wp + 1'b1;
		end
		if (pop)
			st_next.rp = st_reg.rp + 1'b1;
		st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
		st_next.room = st_next.cnt < (AW+1)'(D);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
			st_reg.room <= 1'b1;
		end else
			st_reg <= st_next;
	end
endmodule : apc_fifo
////////////////////////////////////////////////////////////////
module apc_codec
	import apc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        start,
	input  wire apc_cfg_t    cfg,
	input  wire apc_smp_t    smp_data,
	input  wire logic        smp_valid,
	output logic             smp_ready,
	output apc_out_t         out_data,
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic             busy,
	output logic             done,
	output logic [35:0]      code_out,
	output apc_pulse_t [7:0] dec_pulses,
	output logic [15:0]      gp_clip,
	output logic [15:0]      mean_g,
	output logic [15:0]      mean_d,
	output logic [15:0]      beta
);
	typedef enum logic [1:0] {S_IDLE, S_DIV, S_RUN} apc_state_t;
	typedef struct packed {
		apc_state_t              st;
		apc_ftype_t              ftype;
		logic [15:0]             mg;
		logic [15:0]             md;
		logic [15:0]             gp;
		logic                    clip;
		logic [31:0]             e_prev;
		logic [7:0]              lag;
		logic [32:0]             den;
		logic [33:0]             rem;
		logic [15:0]             quo;
		logic [3:0]              step;
		logic [15:0]             beta;
		logic [5:0]              n;
		logic signed [15:0]      h_prev;
		logic [NSMP-1:0][15:0]   hist;
		apc_out_t                od;
		logic                    ov;
		logic                    done;
		logic [35:0]             code;
		apc_pulse_t [7:0]        dec;
	} apc_st_t;
	apc_st_t s_reg, s_next;
	apc_smp_t f_data;
	logic f_valid, f_take;

	// Signed Q14 product, kept to 16 bits
	function automatic logic signed [15:0] mulq(input logic signed [15:0] a,
			input logic signed [16:0] b);
		logic signed [32:0] p;
		p = a * b;
		return p[Q+15:Q];
	endfunction : mulq

	// Unsigned Q14 weighted sum of old and new value
	function automatic logic [15:0] blend(input logic [15:0] o, input logic [15:0] ko,
			input logic [15:0] v, input logic [15:0] kv);
		logic [32:0] s;
		s = 33'(o * ko) + 33'(v * kv);
		return s[Q+15:Q];
	endfunction : blend

	// Packs the pulse set; track 0 lands in the top bits
	function automatic logic [35:0] pack(input apc_ftype_t ft, input apc_pulse_t [7:0] p);
		logic [35:0] c;
		logic [3:0]  pa, pb, p0, p1;
		logic        s;
		apc_pulse_t  ev, od;
		c = '0;
		if (ft == APC_FULL_RATE_TYPE) begin
			for (int k = 0; k < NTRK; k++) begin
				pa = p[k].pos[5:2];
				pb = p[k+NTRK].pos[5:2];
				if (p[k].neg == p[k+NTRK].neg) begin
					p0 = (pa < pb) ? pa : pb;
					p1 = (pa < pb) ? pb : pa;
					s  = p[k].neg;
				end else begin
					p0 = (pa > pb) ? pa : pb;
					p1 = (pa > pb) ? pb : pa;
					s  = (pa > pb) ? p[k].neg : p[k+NTRK].neg;
				end
				c[35-FR_BITS*k -: FR_BITS] = {s, p0, p1};
			end
		end else begin
			ev = p[0].pos[0] ? p[1] : p[0];
			od = p[0].pos[0] ? p[0] : p[1];
			c[2*HR_BITS-1:0] = {ev.neg, ev.pos[5:1], od.neg, od.pos[5:1]};
		end
		return c;
	endfunction : pack

	// Unpacks a code word back into pulses
	function automatic apc_pulse_t [7:0] unpack(input apc_ftype_t ft, input logic [35:0] c);
		apc_pulse_t [7:0] p;
		logic [FR_BITS-1:0] t;
		p = '0;
		if (ft == APC_FULL_RATE_TYPE) begin
			for (int k = 0; k < NTRK; k++) begin
				t = c[35-FR_BITS*k -: FR_BITS];
				p[k].pos      = {t[7:4], 2'(k)};
				p[k].neg      = t[8];
				p[k+NTRK].pos = {t[3:0], 2'(k)};
				p[k+NTRK].neg = (t[7:4] > t[3:0]) ? ~t[8] : t[8];
			end
		end else begin
			p[0] = '{neg: c[11], pos: {c[10:6], 1'b0}};
			p[1] = '{neg: c[5],  pos: {c[4:0], 1'b1}};
		end
		return p;
	endfunction : unpack

	apc_fifo #(.W($bits(apc_smp_t)), .D(FIFO_DEPTH)) u_fifo (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.s_data   (smp_data),
		.s_valid  (smp_valid),
		.s_ready  (smp_ready),
		.m_data   (f_data),
		.m_valid  (f_valid),
		.m_ready  (f_take)
	);

	// Downstream stall holds the FIFO, which then fills
	assign f_take = (s_reg.st == S_RUN) && (!s_reg.ov || out_ready);

	always_comb begin
		logic [15:0] g1, d1, gcl;
		logic        rst_type, cl;
		logic [7:0]  t;
		logic [6:0]  back;
		logic signed [15:0] h1, h2, fb;
		s_next = s_reg;
		s_next.done = 1'b0;
		g1 = '0; d1 = '0; gcl = '0; rst_type = 1'b0; cl = 1'b0;
		t = '0; back = '0; h1 = '0; h2 = '0; fb = '0;
		if (s_reg.ov && out_ready)
			s_next.ov = 1'b0;
		case (s_reg.st)
			S_IDLE: begin
				if (start) begin
					rst_type = cfg.ftype == APC_EIGHTH_RATE_TYPE || cfg.ftype == APC_QUARTER_RATE_TYPE
						|| cfg.ftype == APC_HALF_RATE_TYPE_UNVOICED;
					g1 = blend(s_reg.mg, K_OLD_G, cfg.gp, K_NEW_G);
					g1 = (g1 < G_INIT) ? G_INIT : g1;
					d1 = blend(s_reg.md, K_OLD_D, cfg.dmin, K_NEW_D);
					d1 = (d1 > D_INIT) ? D_INIT : d1;
					cl = (g1 >= G_HIGH && d1 <= D_LOW)
						|| (g1 > G_ONE && (34'(cfg.tgt_energy) << DROP_SH) < 34'(s_reg.e_prev));
					cl = cl && !rst_type;
					gcl = (cl && cfg.gp > GP_CAP) ? GP_CAP : cfg.gp;
					s_next.mg = rst_type ? G_INIT : g1;
					s_next.md = rst_type ? D_INIT : d1;
					s_next.gp = gcl;
					s_next.clip = cl;
					s_next.e_prev = cfg.tgt_energy;
					s_next.ftype = cfg.ftype;
					s_next.lag = cfg.pitch_int;
					s_next.den = 33'(cfg.ev) + 33'(cfg.ec);
					// Whole part of Ev / (Ev + Ec) is one only when Ec is zero
					s_next.rem = (cfg.ec == '0) ? '0 : 34'(cfg.ev);
					s_next.quo = 16'(cfg.ec == '0 && cfg.ev != '0);
					s_next.step = '0;
					s_next.n = '0;
					s_next.h_prev = '0;
					s_next.code = pack(cfg.ftype, cfg.pulses);
					s_next.dec = unpack(cfg.ftype, cfg.code_in);
					s_next.st = S_DIV;
				end
			end
			S_DIV: begin
				// Restoring division, one quotient bit a cycle
				s_next.rem = s_reg.rem << 1;
				s_next.quo = s_reg.quo << 1;
				if (s_next.rem >= 34'(s_reg.den) && s_reg.den != '0) begin
					s_next.rem = s_next.rem - 34'(s_reg.den);
					s_next.quo[0] = 1'b1;
				end
				s_next.step = s_reg.step + 1'b1;
				if (s_reg.step == 4'(DIV_STEPS - 1)) begin
					s_next.beta = s_next.quo >> 1;
					s_next.st = S_RUN;
				end
			end
			S_RUN: begin
				if (f_take && f_valid) begin
					h1 = f_data.h - mulq(s_reg.h_prev, 17'(s_reg.beta));
					t = (s_reg.ftype == APC_HALF_RATE_TYPE_VOICED) ? f_data.t : s_reg.lag;
					back = 7'(s_reg.n) - 7'(t[5:0]);
					// Lags of 64 or more reach outside the response
					if (t != '0 && t < 8'(NSMP) && !back[6])
						fb = mulq(s_reg.hist[back[5:0]], 17'(K_PER));
					h2 = h1 + fb;
					s_next.hist[s_reg.n] = h2;
					s_next.h_prev = f_data.h;
					s_next.od.h = h2;
					s_next.od.x2 = f_data.x - mulq(f_data.y, 17'(s_reg.gp));
					s_next.ov = 1'b1;
					s_next.n = s_reg.n + 1'b1;
					if (s_reg.n == 6'(NSMP - 1)) begin
						s_next.done = 1'b1;
						s_next.st = S_IDLE;
					end
				end
			end
			default: s_next.st = S_IDLE;
		endcase
	end

	// Means come up at their documented start values
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_reg <= '0;
			s_reg.mg <= G_INIT;
			s_reg.md <= D_INIT;
		end else
			s_reg <= s_next;
	end

	assign busy       = s_reg.st != S_IDLE;
	assign done       = s_reg.done;
	assign code_out   = s_reg.code;
	assign dec_pulses = s_reg.dec;
	assign gp_clip    = s_reg.gp;
	assign mean_g     = s_reg.mg;
	assign mean_d     = s_reg.md;
	assign beta       = s_reg.beta;
	assign out_data   = s_reg.od;
	assign out_valid  = s_reg.ov;

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	AST_GFLOOR: assert property (mean_g >= G_INIT) else $error("mean gain under floor");
	AST_DCAP: assert property (mean_d <= D_INIT) else $error("mean distance over cap");
	AST_CLIP: assert property (s_reg.clip && busy |-> gp_clip <= GP_CAP) else $error("gain not clipped");
	AST_RST_MEANS: assert property (!busy && start && cfg.ftype == APC_QUARTER_RATE_TYPE
		|=> mean_g == G_INIT && mean_d == D_INIT) else $error("means not reset");
	AST_BETA: assert property (beta <= BETA_MAX) else $error("beta out of range");
	AST_DONE: assert property (done |-> $past(s_reg.st) == S_RUN && $past(s_reg.n) == 6'h3F)
		else $error("done not after last sample");
	AST_FR_DEC: assert property (done && s_reg.ftype == APC_FULL_RATE_TYPE |->
		dec_pulses[5].pos[1:0] == 2'h1 && dec_pulses[4].neg ==
		((dec_pulses[0].pos > dec_pulses[4].pos) ? ~dec_pulses[0].neg : dec_pulses[0].neg))
		else $error("full rate decode wrong");
	AST_HR_DEC: assert property (done && s_reg.ftype == APC_HALF_RATE_TYPE_GENERIC |->
		!dec_pulses[0].pos[0] && dec_pulses[1].pos[0]) else $error("half rate tracks wrong");
	AST_BUSY: assert property (busy && !done ##1 busy |-> ##[0:300] !busy || out_valid)
		else $error("subframe stalled without output");

	COV_FR: cover property (done && s_reg.ftype == APC_FULL_RATE_TYPE);
	COV_HR: cover property (done && s_reg.ftype == APC_HALF_RATE_TYPE_VOICED);
	COV_CLIP: cover property (done && s_reg.clip);
	COV_FULL: cover property (!smp_ready);
endmodule : apc_codec
`default_nettype wire

// ==== test/apc_partner.sv ====
// Upstream sample source and downstream sink model for the pulse index codec.
// Assumes the bench clock; drives its lines at the falling edge.
`default_nettype none
module apc_partner
	import apc_pkg::*;
(
	input  wire logic     core_clk,
	input  wire logic     go,
	input  wire logic     slow,
	output apc_smp_t      smp_data,
	output logic          smp_valid,
	input  wire logic     smp_ready,
	input  wire apc_out_t out_data,
	input  wire logic     out_valid,
	output logic          out_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	apc_smp_t mem [64];
	apc_out_t got [64];
	int       n_in  = 64;
	int       n_out = 0;
	logic     took  = 1'b0;
	logic     ph    = 1'b0;
	initial begin
		smp_data = '0;
		smp_valid = 1'b0;
		out_ready = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// Handshakes seen at the rising edge; go restarts one subframe of 64
	always @(posedge core_clk) begin
		took = smp_valid && smp_ready;
		if (out_valid && out_ready && n_out < 64) begin
			got[n_out] = out_data;
			n_out++;
		end
		if (go) begin
			n_in = 0;
			n_out = 0;
		end
	end
	// Idle data bus shows the inverse, so a stale sample cannot pass
	always @(negedge core_clk) begin
		if (took)
			n_in++;
		took = 1'b0;
		smp_valid <= (n_in < 64);
		smp_data <= (n_in < 64) ? mem[n_in[5:0]] : ~smp_data;
		ph = ~ph;
		out_ready <= !slow || ph; // Slow mode stalls every other cycle
	end
endmodule : apc_partner
`default_nettype wire

// ==== test/apc_codec_test.sv ====
// Self-checking bench for the pulse index codec with source/sink model.
// Assumes apc_pkg and the design files are compiled first.
`default_nettype none
module apc_codec_test
	import apc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef apc_pulse_t [7:0] apc_pset_t;
	typedef struct packed {
		apc_ftype_t  ft;
		logic [47:0] ps;
		logic [7:0]  ng;
		logic [35:0] ci;
	} apc_row_t;
	localparam logic [47:0] PA = {6'h3F, 6'h06, 6'h01, 6'h3C, 6'h03, 6'h3A, 6'h05, 6'h00};
	localparam logic [47:0] PB = {6'h3B, 6'h32, 6'h0D, 6'h00, 6'h3F, 6'h02, 6'h29, 6'h04};
	// Pulse sets and codes to decode, one subframe each
	apc_row_t rows [6] = '{
		'{APC_FULL_RATE_TYPE, PA, 8'h00, 36'h000000000},
		'{APC_FULL_RATE_TYPE, PA, 8'h0F, 36'h9A53C71E2},
		'{APC_FULL_RATE_TYPE, PA, 8'hA5, 36'h123456789},
		'{APC_FULL_RATE_TYPE, PB, 8'h5A, 36'hFFFFFFFFF},
		'{APC_HALF_RATE_TYPE_GENERIC, 48'h0000000007FE, 8'h01, 36'h000000FC1},
		'{APC_HALF_RATE_TYPE_VOICED, 48'h000000000FC0, 8'h02, 36'h000000820}};
	apc_ftype_t rt [3] = '{APC_QUARTER_RATE_TYPE, APC_EIGHTH_RATE_TYPE, APC_HALF_RATE_TYPE_UNVOICED};
	logic             core_clk = 1'b0;
	logic             rst_b    = 1'b0;
	logic             start    = 1'b0;
	logic             go       = 1'b0;
	logic             slow     = 1'b1;
	apc_cfg_t         cfg      = '0;
	apc_smp_t         smp_data;
	logic             smp_valid, smp_ready, out_valid, out_ready, busy, done;
	apc_out_t         out_data;
	logic [35:0]      code_out;
	apc_pulse_t [7:0] dec_pulses;
	logic [15:0]      gp_clip, mean_g, mean_d, beta;
	int               fail_count = 0;
	int               checks     = 0;
	int               cyc        = 0;

	always #25 core_clk = ~core_clk;

	apc_codec dut_u (.core_clk, .rst_b, .start, .cfg, .smp_data, .smp_valid, .smp_ready, .out_data,
		.out_valid, .out_ready, .busy, .done, .code_out, .dec_pulses, .gp_clip, .mean_g, .mean_d, .beta);
	apc_partner pm_u (.core_clk, .go, .slow, .smp_data, .smp_valid, .smp_ready, .out_data, .out_valid,
		.out_ready);
	////////////////////////////////////////////////////////////////
	// Compare tasks and the closing report
	task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk16
	task automatic chkw(input string nm, input logic [55:0] e, input logic [55:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chkw
	task automatic chkb(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %b seen %b", nm, e, g);
		end
	endtask : chkb
	task automatic summarize;
		if (fail_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////
	// Expected codes worked out independently of the design
	function automatic apc_pset_t mkp(input logic [47:0] ps, input logic [7:0] ng);
		apc_pset_t r;
		for (int k = 0; k < 8; k++)
			r[k] = {ng[k], ps[6*k +: 6]};
		return r;
	endfunction : mkp
	function automatic logic [35:0] enc(input apc_ftype_t ft, input apc_pset_t p);
		logic [35:0] c;
		logic [3:0]  a, b;
		logic        s;
		c = '0;
		if (ft != APC_FULL_RATE_TYPE)
			return {24'h000000, p[0].neg, p[0].pos[5:1], p[1].neg, p[1].pos[5:1]};
		for (int k = 0; k < 4; k++) begin
			a = p[k].pos[5:2];
			b = p[k+4].pos[5:2];
			s = p[k].neg;
			if (p[k].neg == p[k+4].neg && a > b)
				{a, b} = {b, a}; // Same signs: smaller first
			else if (p[k].neg != p[k+4].neg && a < b) begin
				{a, b} = {b, a}; // Differing signs: larger first
				s = p[k+4].neg;
			end
			c[35-9*k -: 9] = {s, a, b};
		end
		return c;
	endfunction : enc
	function automatic apc_pset_t dec(input apc_ftype_t ft, input logic [35:0] ci);
		apc_pset_t d;
		logic [8:0] f;
		d = '0;
		if (ft != APC_FULL_RATE_TYPE) begin
			d[0] = {ci[11], ci[10:6], 1'b0};
			d[1] = {ci[5], ci[4:0], 1'b1};
			return d;
		end
		for (int k = 0; k < 4; k++) begin
			f = ci[35-9*k -: 9];
			d[k] = {f[8], f[7:4], 2'(k)};
			d[k+4] = {(f[7:4] > f[3:0]) ? ~f[8] : f[8], f[3:0], 2'(k)};
		end
		return d;
	endfunction : dec
	////////////////////////////////////////////////////////////////
	// One subframe: start with config, 64 samples, wait for done
	task automatic sub(input apc_ftype_t ft, input logic [15:0] gp, input logic [15:0] dm,
		input logic [31:0] en, input logic [7:0] pi, input logic [31:0] ev, input logic [31:0] ec,
		input apc_pset_t pl, input logic [35:0] ci, input logic feed);
		int n;
		@(negedge core_clk);
		cfg = '{ft, gp, dm, en, pi, ev, ec, pl, ci};
		start = 1'b1;
		go = feed;
		@(negedge core_clk);
		start = 1'b0;
		go = 1'b0;
		chkb("busy", 1'b1, busy);
		n = 0;
		while (done !== 1'b1 && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
		chkb("done", 1'b1, done);
		// Last output may still wait for the sink's ready
		while (out_valid !== 1'b0 && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
		chkb("out_valid", 1'b0, out_valid);
		chkb("smp_ready", 1'b1, smp_ready);
	endtask : sub
	// Hang guard: well above the expected run length
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 64; i++)
			pm_u.mem[i] = '{(i == 0) ? 16'h4000 : 16'h0000, 16'(i * 16), 16'h0100, 8'h00};
		repeat (20) @(negedge core_clk);
		chk16("mean_g", 16'h2666, mean_g);
		chk16("mean_d", 16'h0078, mean_d);
		chkb("smp_ready", 1'b1, smp_ready);
		rst_b = 1'b1;
		// Samples sent while idle fill the buffer until it refuses
		@(negedge core_clk);
		go = 1'b1;
		@(negedge core_clk);
		go = 1'b0;
		repeat (20) @(negedge core_clk);
		chkb("smp_ready", 1'b0, smp_ready);
		chkb("busy", 1'b0, busy);
		sub(APC_FULL_RATE_TYPE, 16'h4000, 16'h01F4, 32'h0, 8'h02, 32'h1, 32'h0, '0, '0, 1'b0);
		chk16("beta", 16'h2000, beta);
		chk16("n_out", 16'h0040, 16'(pm_u.n_out));
		chk16("h0", 16'h4000, pm_u.got[0].h);
		chk16("h1", 16'hE000, pm_u.got[1].h);
		chk16("h2", 16'h3666, pm_u.got[2].h);
		chk16("h3", 16'hE4CD, pm_u.got[3].h);
		for (int i = 0; i < 64; i++)
			chk16("x2", 16'(i * 16) - 16'h0100, pm_u.got[i].x2);
		// Table of pulse sets: encode and decode
		foreach (rows[r]) begin
			sub(rows[r].ft, 16'h0000, 16'h01F4, 32'h0, 8'h00, 32'h0, 32'h0, mkp(rows[r].ps, rows[r].ng),
				rows[r].ci, 1'b1);
			chkw("code_out", enc(rows[r].ft, mkp(rows[r].ps, rows[r].ng)), code_out);
			chkw("dec_pulses", dec(rows[r].ft, rows[r].ci), dec_pulses);
			chk16("mean_g", 16'h2666, mean_g);
			chk16("mean_d", 16'h0078, mean_d);
			chk16("beta", 16'h0000, beta);
		end
		// Raise the mean gain above one with distance held at 120
		for (int i = 0; i < 15; i++)
			sub(APC_FULL_RATE_TYPE, 16'h4CCD, 16'h0078, 32'h1000, 8'h00, 32'h3, 32'h3, '0, '0, 1'b1);
		chk16("gp_clip", 16'h4CCD, gp_clip);
		chk16("beta", 16'h1000, beta);
		sub(APC_FULL_RATE_TYPE, 16'h4CCD, 16'h0078, 32'h0400, 8'h00, 32'h3, 32'h3, '0, '0, 1'b1);
		chk16("gp_clip", 16'h4CCD, gp_clip);
		sub(APC_FULL_RATE_TYPE, 16'h4CCD, 16'h0078, 32'h00FF, 8'h00, 32'h3, 32'h3, '0, '0, 1'b1);
		chk16("gp_clip", 16'h3CCD, gp_clip);
		// Mean distance falls below 60 over several subframes
		for (int i = 0; i < 6; i++) begin
			sub(APC_FULL_RATE_TYPE, 16'h4CCD, 16'h0000, 32'h00FF, 8'h00, 32'h3, 32'h3, '0, '0, 1'b1);
			if (i == 0)
				chk16("gp_clip", 16'h4CCD, gp_clip);
		end
		chk16("gp_clip", 16'h3CCD, gp_clip);
		// Low-rate types restore both means and skip clipping
		foreach (rt[i]) begin
			sub(rt[i], 16'h4CCD, 16'h0000, 32'h0001, 8'h00, 32'h3, 32'h3, '0, '0, 1'b1);
			chk16("mean_g", 16'h2666, mean_g);
			chk16("mean_d", 16'h0078, mean_d);
			chk16("gp_clip", 16'h4CCD, gp_clip);
		end
		summarize();
	end
endmodule : apc_codec_test
`default_nettype wire
